//--- logic/hv_prog_host.sv
`timescale 1ns/10ps
// Function
// R1: flash write command loads with action 10
// R2: action 00, bs1 0 loads address low
// R3: action 01, bs1 0 loads data low
// R4: action 01, bs1 1 loads data high
// R5: page load pulse with bs1 high
// R6: software repeats word and page steps
// R7: device maps low address to page word
// R8: action 00, bs1 1 loads address high
// R9: write pulse low, then wait ready
// R10: nop command ends write session
// R11: eeprom write uses 0x11, bs1 0 write
// R12: flash read low/high by bs1
// R13: eeprom read with bs1 0
// R14: fuse write target by bs1, bs2
// R15: byte selects return to zero afterwards
// R16: lock write command then write pulse
// R17: device refuses boot lock in mode 3
// R18: fuse/lock read selected by bs2, bs1
// R19: signature read at low address 0..2
// R20: calibration read with bs1 1
// R21: action 11 is no action
// R22: ready low while device busy
// R23: host drives data only while oe high
// R24: command kept across operations
// R25: device syncs strobes to its clock; hv_dev_model acts on raw strobe edges
module hv_prog_host (
  input  wire logic        clk,              // 40 MHz clock
  input  wire logic        rst_n,            // sync reset, active low
  // axi4-lite slave
  input  wire logic [3:0]  s_awaddr,         // write address
  input  wire logic        s_awvalid,        // write address valid
  output logic             s_awready,        // write address ready
  input  wire logic [31:0] s_wdata,          // write data
  input  wire logic [3:0]  s_wstrb,          // write strobes
  input  wire logic        s_wvalid,         // write data valid
  output logic             s_wready,         // write data ready
  output logic [1:0]       s_bresp,          // write response
  output logic             s_bvalid,         // write response valid
  input  wire logic        s_bready,         // write response ready
  input  wire logic [3:0]  s_araddr,         // read address
  input  wire logic        s_arvalid,        // read address valid
  output logic             s_arready,        // read address ready
  output logic [31:0]      s_rdata,          // read data
  output logic [1:0]       s_rresp,          // read response
  output logic             s_rvalid,         // read data valid
  input  wire logic        s_rready,         // read data ready
  // device pins
  output logic             action_select_hi, // action code bit 1
  output logic             action_select_lo, // action code bit 0
  output logic             low_byte_select,  // byte select 1
  output logic             second_byte_select, // byte select 2
  output logic             load_strobe,      // load clock pulse
  output logic             page_load_strobe, // page latch pulse
  output logic             wr_n,             // write pulse, low
  output logic             oe_n,             // output enable, low
  output logic [7:0]       data_out,         // data bus drive value
  output logic             data_oe,          // high while host drives
  input  wire logic [7:0]  data_in,          // data bus level
  input  wire logic        ready_busy_out    // device ready level
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_SETUP = 3'h1, ST_PULSE = 3'h2,
    ST_HOLD = 3'h3, ST_WAITBZ = 3'h4, ST_WAITRD = 3'h5
  } state_e;
  state_e             state, next_state;
  hv_prog_pkg::pins_s pins, next_pins;
  hv_prog_pkg::op_e   op, next_op;
  logic [7:0]         arg, next_arg;
  logic [7:0]         rdata, next_rdata;
  logic               busy, next_busy;
  logic [7:0]         dout, next_dout;
  logic               doe, next_doe;
  logic               tstart, next_tstart;
  logic               tdone;
  logic [7:0]         sdata;
  logic               srdy;
  pin_sync #(.W(9)) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .async  ({data_in, ready_busy_out}),
    .synced ({sdata, srdy})
  );
  pulse_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (tstart),
    .count (hv_prog_pkg::PULSE_CNT),
    .done  (tdone)
  );
  // axi write side: accept address and data in either order
  logic       aw_got, next_aw_got;
  logic       w_got, next_w_got;
  logic [3:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic       bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic       arready, next_arready;
  logic       rvalid, next_rvalid;
  logic [31:0] rd_bus, next_rd_bus;
  logic [1:0] rresp, next_rresp;
  logic       start_op;
  logic       wr_rdy;
  function automatic logic [1:0] action_of(hv_prog_pkg::op_e o);
    unique case (o)
      hv_prog_pkg::OP_LOAD_CMD:  action_of = hv_prog_pkg::ACT_CMD;   // R1
      hv_prog_pkg::OP_LOAD_ADDR: action_of = hv_prog_pkg::ACT_ADDR;  // R2
      hv_prog_pkg::OP_LOAD_DATA: action_of = hv_prog_pkg::ACT_DATA;  // R3
      default:                   action_of = hv_prog_pkg::ACT_IDLE;  // R21
    endcase
  endfunction
  always_comb begin
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_aw_q    = aw_q;
    next_w_q     = w_q;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_arready = 1'b0;
    next_rvalid  = rvalid;
    next_rd_bus  = rd_bus;
    next_rresp   = rresp;
    start_op     = 1'b0;
    if (s_awvalid && !aw_got && !bvalid) begin
      next_aw_got = 1'b1;
      next_aw_q   = s_awaddr;
    end
    if (s_wvalid && !w_got && !bvalid) begin
      next_w_got = 1'b1;
      next_w_q   = s_wdata;
    end
    if (aw_got && w_got) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = 2'h0;
      if (aw_q == hv_prog_pkg::REG_CTRL) begin
        if (busy) begin
          next_bresp = 2'h2;
        end else begin
          start_op = 1'b1;
        end
      end else if (aw_q != hv_prog_pkg::REG_ARG) begin
        next_bresp = 2'h2;
      end
    end
    if (bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_arvalid && !arready && !rvalid) begin
      next_arready = 1'b1;
      next_rvalid  = 1'b1;
      next_rresp   = 2'h0;
      unique case (s_araddr)
        hv_prog_pkg::REG_CTRL:   next_rd_bus = {29'h0, op};
        hv_prog_pkg::REG_ARG:    next_rd_bus = {24'h0, arg};
        hv_prog_pkg::REG_STATUS: next_rd_bus = {30'h0, srdy, busy};
        hv_prog_pkg::REG_RDATA:  next_rd_bus = {24'h0, rdata};
        default: begin
          next_rd_bus = 32'h0;
          next_rresp  = 2'h2;
        end
      endcase
    end
    if (rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_q    <= 4'h0;
      w_q     <= 32'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rd_bus  <= 32'h0;
      rresp   <= 2'h0;
      wr_rdy  <= 1'b0;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      aw_q    <= next_aw_q;
      w_q     <= next_w_q;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rd_bus  <= next_rd_bus;
      rresp   <= next_rresp;
      wr_rdy  <= next_aw_got && next_w_got;
    end
  end
  // pin sequencer: setup, pulse, hold, optional busy wait
  always_comb begin
    next_state  = state;
    next_pins   = pins;
    next_op     = op;
    next_arg    = arg;
    next_rdata  = rdata;
    next_busy   = busy;
    next_dout   = dout;
    next_doe    = doe;
    next_tstart = 1'b0;
    if (aw_got && w_got && aw_q == hv_prog_pkg::REG_ARG && !busy) begin
      next_arg = w_q[7:0];
    end
    unique case (state)
      ST_IDLE: begin
        if (start_op) begin
          next_op        = hv_prog_pkg::op_e'(w_q[hv_prog_pkg::CTRL_OP_LSB +: 3]);
          next_busy      = 1'b1;
          next_pins.bs1  = w_q[hv_prog_pkg::CTRL_BS1_BIT];  // R4 R8 R14
          next_pins.bs2  = w_q[hv_prog_pkg::CTRL_BS2_BIT];  // R14 R18
          next_pins.action = action_of(hv_prog_pkg::op_e'(w_q[2:0]));
          if (w_q[2:0] == hv_prog_pkg::OP_READ) begin
            next_doe       = 1'b0;
            next_pins.oe_n = 1'b0;  // R12 R13 R18 R19 R20
          end else begin
            next_doe  = 1'b1;  // R23
            next_dout = arg;
          end
          next_tstart = 1'b1;
          next_state  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tdone) begin
          unique case (op)
            hv_prog_pkg::OP_LOAD_CMD, hv_prog_pkg::OP_LOAD_ADDR,
            hv_prog_pkg::OP_LOAD_DATA: next_pins.load = 1'b1;  // R1 R2 R3 R10
            hv_prog_pkg::OP_PAGE_LATCH: next_pins.page_load = 1'b1;  // R5
            hv_prog_pkg::OP_WRITE:      next_pins.wr_n = 1'b0;  // R9 R11 R16
            default:                    next_rdata = sdata;
          endcase
          next_tstart = 1'b1;
          next_state  = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tdone) begin
          next_pins.load      = 1'b0;
          next_pins.page_load = 1'b0;
          next_pins.wr_n      = 1'b1;
          next_pins.oe_n      = 1'b1;
          next_tstart         = 1'b1;
          next_state          = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tdone) begin
          next_doe         = 1'b0;
          next_pins.action = hv_prog_pkg::ACT_IDLE;
          next_pins.bs1    = 1'b0;  // R15
          next_pins.bs2    = 1'b0;  // R15
          if (op == hv_prog_pkg::OP_WRITE) begin
            next_state = ST_WAITBZ;
          end else begin
            next_busy  = 1'b0;  // R6
            next_state = ST_IDLE;
          end
        end
      end
      ST_WAITBZ: begin
        if (!srdy) begin
          next_state = ST_WAITRD;
        end
      end
      ST_WAITRD: begin
        if (srdy) begin
          next_busy  = 1'b0;  // R9 R22
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state  <= ST_IDLE;
      pins   <= hv_prog_pkg::PINS_IDLE;
      op     <= hv_prog_pkg::OP_LOAD_CMD;
      arg    <= 8'h00;
      rdata  <= 8'h00;
      busy   <= 1'b0;
      dout   <= 8'h00;
      doe    <= 1'b0;
      tstart <= 1'b0;
    end else begin
      state  <= next_state;
      pins   <= next_pins;
      op     <= next_op;
      arg    <= next_arg;
      rdata  <= next_rdata;
      busy   <= next_busy;
      dout   <= next_dout;
      doe    <= next_doe;
      tstart <= next_tstart;
    end
  end
  assign s_awready          = wr_rdy;
  assign s_wready           = wr_rdy;
  assign s_bvalid           = bvalid;
  assign s_bresp            = bresp;
  assign s_arready          = arready;
  assign s_rvalid           = rvalid;
  assign s_rdata            = rd_bus;
  assign s_rresp            = rresp;
  assign action_select_hi   = pins.action[1];
  assign action_select_lo   = pins.action[0];
  assign low_byte_select    = pins.bs1;
  assign second_byte_select = pins.bs2;
  assign load_strobe        = pins.load;
  assign page_load_strobe   = pins.page_load;
  assign wr_n               = pins.wr_n;
  assign oe_n               = pins.oe_n;
  assign data_out           = dout;
  assign data_oe            = doe;
  a_bus_vs_oe: assert property (@(posedge clk) disable iff (!rst_n)  // R23
    !(doe && !pins.oe_n)) else $error("host drives data while oe low");
  a_load_action: assert property (@(posedge clk) disable iff (!rst_n)  // R21
    $rose(pins.load) |-> pins.action != hv_prog_pkg::ACT_IDLE)
    else $error("load strobe with idle action");
  a_wr_waits_ready: assert property (@(posedge clk) disable iff (!rst_n)  // R9
    $rose(pins.wr_n) && op == hv_prog_pkg::OP_WRITE |-> busy [*4])
    else $error("write finished before busy wait");
  a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)  // R2
    $rose(pins.load) |-> pins.load [*8] ##1 pins.load ##1 pins.load)
    else $error("load pulse too short");
  a_page_bs1: assert property (@(posedge clk) disable iff (!rst_n)  // R5
    pins.page_load |-> pins.bs1) else $error("page load without bs1");
  a_wr_bs_clear: assert property (@(posedge clk) disable iff (!rst_n)  // R15
    $rose(state == ST_WAITBZ) |-> !pins.bs1 && !pins.bs2)
    else $error("byte select left high");
  a_rd_capture: assert property (@(posedge clk) disable iff (!rst_n)  // R12
    state == ST_SETUP && tdone && op == hv_prog_pkg::OP_READ |=> rdata == $past(sdata))
    else $error("read byte not captured");
  a_data_setup: assert property (@(posedge clk) disable iff (!rst_n)  // R1
    $rose(pins.load) |-> doe && $stable(dout)) else $error("data not set up");
endmodule // hv_prog_host

//--- logic/hv_prog_pkg.sv
package hv_prog_pkg;

  // command bytes
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_SIG     = 8'h08;

  // action select codes {hi,lo}
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // pulse width and setup time
  localparam int PULSE_NS     = 250;
  localparam int CLK_NS       = 25;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYCLES);

  // register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ARG    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA  = 4'hc;

  // ctrl fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_BS1_BIT = 4;
  localparam int CTRL_BS2_BIT = 5;

  // operations a software write to ctrl starts
  typedef enum logic [2:0] {
    OP_LOAD_CMD   = 3'h0,
    OP_LOAD_ADDR  = 3'h1,
    OP_LOAD_DATA  = 3'h2,
    OP_PAGE_LATCH = 3'h3,
    OP_WRITE      = 3'h4,
    OP_READ       = 3'h5
  } op_e;

  typedef struct packed {
    logic [1:0] action;
    logic       bs1;
    logic       bs2;
    logic       load;
    logic       page_load;
    logic       wr_n;
    logic       oe_n;
  } pins_s;

  localparam pins_s PINS_IDLE = '{action: 2'h3, bs1: 1'b0, bs2: 1'b0, load: 1'b0,
                                  page_load: 1'b0, wr_n: 1'b1, oe_n: 1'b1};

endpackage

//--- logic/pin_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for device inputs
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // system clock
  input  wire logic         rst_n,  // sync reset
  input  wire logic [W-1:0] async,  // raw pin level
  output logic      [W-1:0] synced  // synchronised level
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta   <= '0;
      synced <= '0;
    end else begin
      meta   <= async;
      synced <= meta;
    end
  end
endmodule // pin_sync

//--- logic/pulse_timer.sv
`timescale 1ns/10ps
// counts down a loaded value, flags done for one cycle
module pulse_timer (
  input  wire logic       clk,    // system clock
  input  wire logic       rst_n,  // sync reset
  input  wire logic       start,  // load count
  input  wire logic [3:0] count,  // cycles to wait
  output logic            done    // one-cycle pulse at end
);
  logic [3:0] cnt;
  logic       run;
  logic [3:0] next_cnt;
  logic       next_run;
  logic       next_done;

  always_comb begin
    next_cnt  = cnt;
    next_run  = run;
    next_done = 1'b0;
    if (start) begin
      next_cnt = count;
      next_run = 1'b1;
    end else if (run) begin
      if (cnt <= 4'h1) begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= 4'h0;
      run  <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      run  <= next_run;
      done <= next_done;
    end
  end
endmodule // pulse_timer

//--- verification/hv_dev_model.sv
`timescale 1ns/10ps
// behavioural programming target on the far side of the pins
module hv_dev_model #(
  parameter int         BUSY_CYC = 40,
  parameter logic [7:0] SIG_0    = 8'h1e, // arbitrary
  parameter logic [7:0] SIG_1    = 8'h2d, // arbitrary
  parameter logic [7:0] SIG_2    = 8'h3c, // arbitrary
  parameter logic [7:0] CAL      = 8'h9b  // arbitrary
) (
  input  wire logic       clk,                // programmer clock
  input  wire logic [1:0] action,             // {hi,lo} action select
  input  wire logic       low_byte_select,    // byte select 1
  input  wire logic       second_byte_select, // byte select 2
  input  wire logic       load_strobe,        // load pulse
  input  wire logic       page_load_strobe,   // page latch pulse
  input  wire logic       wr_n,               // write pulse, low
  input  wire logic       oe_n,               // output enable, low
  input  wire logic [7:0] bus,                // data bus level
  output logic      [7:0] dev_data,           // value driven on bus
  output logic            dev_oe,             // high while driving
  output logic            ready_busy_out      // 1 ready, 0 busy
);
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  a_lo, a_hi, d_lo, d_hi;
  logic [7:0]  fuse_lo = 8'hff;
  logic [7:0]  fuse_hi = 8'hff;
  logic [7:0]  fuse_ext = 8'hff;
  logic [7:0]  lock_byte = 8'hff;
  logic        busy = 1'b0;
  logic [15:0] flash [0:65535];
  logic [15:0] fbuf [0:15];
  logic [7:0]  eep [0:65535];
  logic [7:0]  ebuf [0:3];
  logic        lock_bit_one, lock_bit_two;
  logic [15:0] wa;

  assign wa = {a_hi, a_lo};
  assign lock_bit_one = lock_byte[0];
  assign lock_bit_two = lock_byte[1];
  assign ready_busy_out = ~busy;
  assign dev_oe = ~oe_n;

  always @* begin
    dev_data = 8'h00;
    case (cmd)
      hv_prog_pkg::CMD_RD_FLASH: dev_data = low_byte_select ? flash[wa][15:8] : flash[wa][7:0];
      hv_prog_pkg::CMD_RD_EEPROM: dev_data = eep[wa];
      hv_prog_pkg::CMD_RD_FUSE: begin
        case ({second_byte_select, low_byte_select})
          2'h0: dev_data = fuse_lo;
          2'h3: dev_data = fuse_hi;
          2'h2: dev_data = fuse_ext;
          default: dev_data = lock_byte;
        endcase
      end
      hv_prog_pkg::CMD_RD_SIG: begin
        if (low_byte_select) dev_data = CAL;
        else dev_data = (a_lo == 8'h00) ? SIG_0 : (a_lo == 8'h01) ? SIG_1 : SIG_2;
      end
      default: dev_data = 8'h00;
    endcase
  end

  always @(posedge load_strobe) begin
    case (action)
      hv_prog_pkg::ACT_CMD: cmd <= bus;
      hv_prog_pkg::ACT_ADDR: begin
        if (low_byte_select) a_hi <= bus;
        else a_lo <= bus;
      end
      hv_prog_pkg::ACT_DATA: begin
        if (low_byte_select) d_hi <= bus;
        else d_lo <= bus;
      end
      default: ;
    endcase
  end

  always @(posedge page_load_strobe) begin
    if (low_byte_select) begin
      fbuf[a_lo[3:0]] <= {d_hi, d_lo};
      ebuf[a_lo[1:0]] <= d_lo;
    end
  end

  always @(negedge wr_n) begin
    busy <= 1'b1;
    case (cmd)
      hv_prog_pkg::CMD_WR_FLASH: begin
        for (int i = 0; i < 16; i++) flash[{a_hi, a_lo[7:4], 4'(i)}] <= fbuf[i];
      end
      hv_prog_pkg::CMD_WR_EEPROM: begin
        for (int i = 0; i < 4; i++) eep[{a_hi, a_lo[7:2], 2'(i)}] <= ebuf[i];
      end
      hv_prog_pkg::CMD_WR_FUSE: begin
        case ({second_byte_select, low_byte_select})
          2'h0: fuse_lo <= d_lo;
          2'h1: fuse_hi <= d_lo;
          2'h2: fuse_ext <= d_lo;
          default: ;
        endcase
      end
      hv_prog_pkg::CMD_WR_LOCK: begin
        if (~lock_bit_one & ~lock_bit_two)
          lock_byte <= {lock_byte[7:6] & d_lo[7:6], lock_byte[5:2], 2'h0};
        else lock_byte <= lock_byte & d_lo;
      end
      default: ;
    endcase
    repeat (BUSY_CYC) @(posedge clk);
    busy <= 1'b0;
  end
endmodule // hv_dev_model

//--- verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
      error_cnt++; \
    end \
  end
module tb_top;
  localparam logic [7:0] SIG [3] = '{8'h1e, 8'h2d, 8'h3c}; // arbitrary
  localparam logic [7:0] CAL     = 8'h9b;                  // arbitrary
  logic        clk, rst_n;
  logic [3:0]  s_awaddr, s_wstrb, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0]  s_bresp, s_rresp, rs;
  logic        action_select_hi, action_select_lo, low_byte_select, second_byte_select;
  logic        load_strobe, page_load_strobe, wr_n, oe_n, data_oe, dev_oe, ready_busy_out;
  logic [7:0]  data_out, dev_data, last_bus;
  wire  [7:0]  bus;
  int          error_cnt, samples_checked;

  // released bus shows the inverse of its last driven value
  assign bus = data_oe ? data_out : (dev_oe ? dev_data : ~last_bus);
  always @(posedge clk) if (data_oe | dev_oe) last_bus <= bus;
  always #12.5 clk = ~clk;

  hv_prog_host u_dut (
    .clk(clk), .rst_n(rst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
    .low_byte_select(low_byte_select), .second_byte_select(second_byte_select),
    .load_strobe(load_strobe), .page_load_strobe(page_load_strobe), .wr_n(wr_n),
    .oe_n(oe_n), .data_out(data_out), .data_oe(data_oe), .data_in(bus),
    .ready_busy_out(ready_busy_out));

  hv_dev_model #(.SIG_0(SIG[0]), .SIG_1(SIG[1]), .SIG_2(SIG[2]), .CAL(CAL)) u_dev (
    .clk(clk), .action({action_select_hi, action_select_lo}),
    .low_byte_select(low_byte_select), .second_byte_select(second_byte_select),
    .load_strobe(load_strobe), .page_load_strobe(page_load_strobe), .wr_n(wr_n),
    .oe_n(oe_n), .bus(bus), .dev_data(dev_data), .dev_oe(dev_oe),
    .ready_busy_out(ready_busy_out));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_fail();
    error_cnt++;
    $display("wait limit used up");
    end_sim();
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int   n;
    @(posedge clk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      aw = s_awready;
      w = s_wready;
      b = s_bvalid;
      r = s_bresp;
      @(posedge clk);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      if (b) begin
        s_bready <= 1'b0;
        break;
      end
    end
    if (n == 200) wait_fail();
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    int   n;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      ar = s_arready;
      v = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge clk);
      if (ar) s_arvalid <= 1'b0;
      if (v) begin
        s_rready <= 1'b0;
        break;
      end
    end
    if (n == 200) wait_fail();
  endtask

  task automatic start_op(input logic [2:0] op, input logic b1, input logic b2,
                          input logic [7:0] arg, input logic [1:0] er);
    axi_wr(hv_prog_pkg::REG_ARG, {24'h0, arg}, rs);
    axi_wr(hv_prog_pkg::REG_CTRL, {26'h0, b2, b1, 1'b0, op}, rs);
    `CHK("ctrl response", er, rs)
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      axi_rd(hv_prog_pkg::REG_STATUS, rd, rs);
      if (rd[0] === 1'b0) break;
    end
    if (n == 300) wait_fail();
    `CHK("byte selects", 2'h0, {second_byte_select, low_byte_select})
    `CHK("action idle", 2'h3, {action_select_hi, action_select_lo})
  endtask

  task automatic do_op(input logic [2:0] op, input logic b1, input logic b2,
                       input logic [7:0] arg);
    start_op(op, b1, b2, arg, 2'h0);
    wait_idle();
  endtask

  task automatic chk_rd(input logic b1, input logic b2, input logic [7:0] e, input string nm);
    do_op(3'h5, b1, b2, 8'h00);
    axi_rd(hv_prog_pkg::REG_RDATA, rd, rs);
    `CHK(nm, e, rd[7:0])
  endtask

  initial begin
    static logic [7:0] fv [3] = '{8'hd2, 8'hd9, 8'hfd};
    static logic [1:0] ws [3] = '{2'h0, 2'h1, 2'h2};
    static logic [1:0] rsel [3] = '{2'h0, 2'h3, 2'h2};
    clk = 1'b0;
    rst_n = 1'b0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    last_bus = 8'h00;
    error_cnt = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("idle pins", 5'h1e, {action_select_hi, action_select_lo, wr_n, oe_n, data_oe})
    axi_rd(hv_prog_pkg::REG_STATUS, rd, rs);
    `CHK("status", 32'h2, rd)
    axi_rd(4'h6, rd, rs);
    `CHK("unmapped resp", 2'h2, rs)
    $display("test reset done");
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_WR_FLASH);
    do_op(3'h1, 1'b1, 1'b0, 8'h02);
    for (int i = 0; i < 2; i++) begin
      do_op(3'h1, 1'b0, 1'b0, 8'h30 + 8'(i));
      do_op(3'h2, 1'b0, 1'b0, 8'ha0 + 8'(i));
      do_op(3'h2, 1'b1, 1'b0, 8'hc0 + 8'(i));
      do_op(3'h3, 1'b1, 1'b0, 8'h00);
    end
    start_op(3'h4, 1'b0, 1'b0, 8'h00, 2'h0);
    start_op(3'h0, 1'b0, 1'b0, 8'h77, 2'h2);
    wait_idle();
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_NOP);
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_RD_FLASH);
    for (int i = 0; i < 2; i++) begin
      do_op(3'h1, 1'b0, 1'b0, 8'h30 + 8'(i));
      chk_rd(1'b0, 1'b0, 8'ha0 + 8'(i), "flash low");
      chk_rd(1'b1, 1'b0, 8'hc0 + 8'(i), "flash high");
    end
    $display("test flash done");
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_WR_EEPROM);
    do_op(3'h1, 1'b1, 1'b0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      do_op(3'h1, 1'b0, 1'b0, 8'h48 + 8'(i));
      do_op(3'h2, 1'b0, 1'b0, 8'h70 + 8'(i));
      do_op(3'h3, 1'b1, 1'b0, 8'h00);
    end
    do_op(3'h4, 1'b0, 1'b0, 8'h00);
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_RD_EEPROM);
    for (int i = 0; i < 4; i++) begin
      do_op(3'h1, 1'b0, 1'b0, 8'h48 + 8'(i));
      chk_rd(1'b0, 1'b0, 8'h70 + 8'(i), "eeprom byte");
    end
    $display("test eeprom done");
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      do_op(3'h2, 1'b0, 1'b0, fv[i]);
      do_op(3'h4, ws[i][0], ws[i][1], 8'h00);
    end
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_RD_FUSE);
    for (int i = 0; i < 3; i++) chk_rd(rsel[i][0], rsel[i][1], fv[i], "fuse byte");
    $display("test fuse done");
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_WR_LOCK);
    do_op(3'h2, 1'b0, 1'b0, 8'hfc);
    do_op(3'h4, 1'b0, 1'b0, 8'h00);
    do_op(3'h2, 1'b0, 1'b0, 8'hc0);
    do_op(3'h4, 1'b0, 1'b0, 8'h00);
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_RD_FUSE);
    chk_rd(1'b1, 1'b0, 8'hfc, "lock byte");
    $display("test lock done");
    do_op(3'h0, 1'b0, 1'b0, hv_prog_pkg::CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      do_op(3'h1, 1'b0, 1'b0, 8'(i));
      chk_rd(1'b0, 1'b0, SIG[i], "signature");
    end
    do_op(3'h1, 1'b0, 1'b0, 8'h00);
    chk_rd(1'b1, 1'b0, CAL, "calibration");
    $display("test signature done");
    end_sim();
  end
endmodule // tb_top
